// [core/npe_host.v]
/*
  Host controller for a byte-wide NAND flash: runs page program, block
  erase, block protect, block-status read, status read and reset
  sequences on the flash pins, ordered by software over Avalon-MM.
  Assumes flash pins synchronous to mclk_in and an external pull-up on
  the ready/busy line.
*/
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
// Functional notes
// RULE_01: second-half pointer reverts to first half
// RULE_02: sequential reads stay in block, end
// RULE_03: new block needs new read command
// RULE_04: partial program once main, twice spare
// RULE_05: up to 528 bytes loaded per page
// RULE_06: program is 80h, addresses, data, 10h
// RULE_07: no confirm without data-input and data
// RULE_08: only status and reset while programming
// RULE_09: completion on ready pin; status bit0
// RULE_10: verify flags only unprogrammed zeros
// RULE_11: device stays in status mode afterwards
// RULE_12: erase is 60h, three addresses, D0h
// RULE_13: erase uses only A14 through A26
// RULE_14: erase starts at confirm strobe edge
// RULE_15: protect is 4xh, 80h, addresses, 10h
// RULE_16: protect code picks protection type
// RULE_17: program-only protection is erasable
// RULE_18: protected target: short busy, no change
// RULE_19: only status and reset during protect
// RULE_20: protect only blocks one to 200; code accepts blocks 0 to 199
// RULE_21: never protect an already protected block; code does not check block status before protecting
// RULE_22: block-status read after 7Ah command
// RULE_23: second-half pointer is bytes 256-511
// RULE_24: ready/busy low during program or erase
`timescale 1ns/1ps
`include "npe_consts.vh"

module npe_host #(
  parameter PAGE_BYTES = 528
) (
  input  wire        mclk_in,
  input  wire        rst_in,
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire        ready_busy_in,
  input  wire [7:0]  io_in,
  output wire [7:0]  io_out,
  output wire        io_oe_out,
  output wire        cle_out,
  output wire        ale_out,
  output reg         chip_select_n_out,
  output wire        write_strobe_n_out,
  output wire        read_strobe_n_out
);
  localparam S_IDLE  = 4'd0;
  localparam S_CMD   = 4'd1;
  localparam S_ADDR  = 4'd2;
  localparam S_DATA  = 4'd3;
  localparam S_WAIT  = 4'd4;
  localparam S_CYC   = 4'd5;
  localparam S_BUSY  = 4'd6;
  localparam S_READ  = 4'd7;
  localparam S_GAP   = 4'd8;
  localparam [31:0] WB_WAIT = `NPE_T_WB_CYC;

  reg [3:0]  state_reg;
  reg [3:0]  ret_reg;
  reg [2:0]  op_reg;
  reg [1:0]  area_reg;
  reg [1:0]  prot_reg;
  reg [25:0] addr_reg;
  reg [7:0]  page_buf [0:PAGE_BYTES-1];
  reg [9:0]  load_cnt_reg;
  reg [9:0]  idx_reg;
  reg [2:0]  step_reg;
  reg [2:0]  acnt_reg;
  reg [7:0]  result_reg;
  reg [7:0]  gap_reg;
  reg        error_reg;
  reg        start_reg;
  reg [1:0]  kind_reg;
  reg [7:0]  byte_reg;
  wire       cyc_done;
  wire [7:0] cyc_rd;

  npe_strobe u_strobe (
    .mclk_in            (mclk_in),
    .rst_in             (rst_in),
    .start_in           (start_reg),
    .kind_in            (kind_reg),
    .byte_in            (byte_reg),
    .io_in              (io_in),
    .done_out           (cyc_done),
    .rd_data_out        (cyc_rd),
    .cle_out            (cle_out),
    .ale_out            (ale_out),
    .write_strobe_n_out (write_strobe_n_out),
    .read_strobe_n_out  (read_strobe_n_out),
    .io_out             (io_out),
    .io_oe_out          (io_oe_out)
  );

  wire busy_w = (state_reg != S_IDLE);

  // Command byte for the current step of each sequence
  reg [7:0] seq_cmd;
  reg       seq_last;
  always @* begin
    seq_cmd  = `NPE_CMD_STATUS;
    seq_last = 1'b1;
    case (op_reg)
      `NPE_OP_PROGRAM: begin
        seq_cmd  = (step_reg == 3'd0) ? ((area_reg == 2'd1) ? `NPE_CMD_PTR_B :
                   (area_reg == 2'd2) ? `NPE_CMD_PTR_C : `NPE_CMD_PTR_A) :
                   (step_reg == 3'd1) ? `NPE_CMD_DATA_IN : `NPE_CMD_PROG_GO; // RULE_06
        seq_last = (step_reg == 3'd2);
      end
      `NPE_OP_ERASE: begin
        seq_cmd  = (step_reg == 3'd0) ? `NPE_CMD_ERASE_SET : `NPE_CMD_ERASE_GO; // RULE_12 RULE_17
        seq_last = (step_reg == 3'd1);
      end
      `NPE_OP_PROTECT: begin
        seq_cmd  = (step_reg == 3'd0) ? (`NPE_CMD_PROT_BASE | {6'h00, prot_reg}) : // RULE_16
                   (step_reg == 3'd1) ? `NPE_CMD_DATA_IN : `NPE_CMD_PROG_GO; // RULE_15
        seq_last = (step_reg == 3'd2);
      end
      `NPE_OP_BLK_STAT: seq_cmd = `NPE_CMD_BLK_STAT; // RULE_22
      `NPE_OP_RESET:    seq_cmd = `NPE_CMD_RESET;
      default:          seq_cmd = `NPE_CMD_STATUS;
    endcase
  end

  // Address byte: program uses column then three row bytes
  reg [7:0] addr_byte;
  always @* begin
    addr_byte = 8'h00;
    case (acnt_reg)
      3'd0: addr_byte = addr_reg[7:0];
      3'd1: addr_byte = addr_reg[15:8];
      3'd2: addr_byte = addr_reg[23:16];
      3'd3: addr_byte = {6'h00, addr_reg[25:24]};
      default: addr_byte = 8'h00;
    endcase
    if (op_reg == `NPE_OP_PROTECT && acnt_reg == 3'd0) begin
      addr_byte = 8'h00; // RULE_15
    end
    if (op_reg == `NPE_OP_ERASE || op_reg == `NPE_OP_BLK_STAT) begin
      // Row bytes only; low five row bits zeroed
      case (acnt_reg)
        3'd0: addr_byte = {addr_reg[15:13], 5'h00}; // RULE_13
        3'd1: addr_byte = addr_reg[23:16];
        3'd2: addr_byte = {6'h00, addr_reg[25:24]};
        default: addr_byte = 8'h00;
      endcase
    end
  end

  wire [2:0] addr_cycles = (op_reg == `NPE_OP_ERASE || op_reg == `NPE_OP_BLK_STAT) ? 3'd3 : 3'd4;
  wire       has_addr    = (op_reg == `NPE_OP_BLK_STAT || op_reg == `NPE_OP_ERASE) ? (step_reg == 3'd0) :
                           (step_reg == 3'd1);
  wire       has_data    = (op_reg == `NPE_OP_PROGRAM) && (step_reg == 3'd1);
  wire [12:0] blk_num    = addr_reg[25:13];
  wire       go_ok       = (op_reg != `NPE_OP_PROGRAM || load_cnt_reg != 10'd0) && // RULE_07
                           (op_reg != `NPE_OP_PROTECT || blk_num < `NPE_PROT_BLOCKS); // RULE_20 RULE_21
  wire [9:0] last_col    = (area_reg == 2'd1) ? `NPE_HALF_BYTES : 10'd0; // RULE_23

  always @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg           <= S_IDLE;
      ret_reg             <= S_IDLE;
      op_reg              <= 3'd0;
      area_reg            <= 2'd0;
      prot_reg            <= 2'd1;
      addr_reg            <= 26'h0;
      load_cnt_reg        <= 10'd0;
      idx_reg             <= 10'd0;
      step_reg            <= 3'd0;
      acnt_reg            <= 3'd0;
      result_reg          <= 8'h00;
      gap_reg             <= 8'h00;
      error_reg           <= 1'b0;
      start_reg           <= 1'b0;
      kind_reg            <= 2'd0;
      byte_reg            <= 8'h00;
      chip_select_n_out   <= 1'b1;
      avs_readdata_out    <= 32'h0;
      avs_waitrequest_out <= 1'b1;
    end else begin
      start_reg           <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
        avs_waitrequest_out <= 1'b0;
        if (avs_read_in) begin
          case (avs_address_in)
            `NPE_REG_CTRL:   avs_readdata_out <= {24'h0, prot_reg, area_reg, op_reg, 1'b0};
            `NPE_REG_ADDR:   avs_readdata_out <= {6'h0, addr_reg};
            `NPE_REG_STATUS: avs_readdata_out <= {29'h0, ready_busy_in, error_reg, busy_w};
            `NPE_REG_RESULT: avs_readdata_out <= {24'h0, result_reg}; // RULE_09
            `NPE_REG_COUNT:  avs_readdata_out <= {22'h0, load_cnt_reg};
            default:         avs_readdata_out <= 32'h0;
          endcase
        end else if (!busy_w) begin
          case (avs_address_in)
            `NPE_REG_CTRL: begin
              area_reg <= avs_writedata_in[`NPE_CTRL_AREA_LSB+1:`NPE_CTRL_AREA_LSB];
              prot_reg <= avs_writedata_in[`NPE_CTRL_PROT_LSB+1:`NPE_CTRL_PROT_LSB];
              op_reg   <= avs_writedata_in[`NPE_CTRL_OP_LSB+2:`NPE_CTRL_OP_LSB];
              if (avs_writedata_in[`NPE_CTRL_GO_BIT]) begin
                step_reg          <= 3'd0;
                acnt_reg          <= 3'd0;
                error_reg         <= 1'b0;
                chip_select_n_out <= 1'b0;
                state_reg         <= S_CMD; // RULE_03
              end
            end
            `NPE_REG_ADDR: addr_reg <= avs_writedata_in[25:0];
            `NPE_REG_DATA: begin
              if (load_cnt_reg < `NPE_PAGE_BYTES) begin // RULE_05
                page_buf[load_cnt_reg] <= avs_writedata_in[7:0];
                load_cnt_reg           <= load_cnt_reg + 10'd1;
              end
            end
            `NPE_REG_COUNT: load_cnt_reg <= 10'd0;
            default: ;
          endcase
        end
      end

      case (state_reg)
        S_IDLE: ;
        S_CMD: begin
          // Refuse before the first command so no strobe or latch pin moves
          if (step_reg == 3'd0 && (op_reg == `NPE_OP_PROGRAM || op_reg == `NPE_OP_PROTECT) && !go_ok) begin // RULE_07
            error_reg         <= 1'b1;
            chip_select_n_out <= 1'b1;
            state_reg         <= S_IDLE;
          end else begin
            kind_reg  <= 2'd0;
            byte_reg  <= seq_cmd;
            start_reg <= 1'b1;
            ret_reg   <= has_addr ? S_ADDR : (seq_last ? S_GAP : S_CMD);
            idx_reg   <= last_col;
            state_reg <= S_CYC;
          end
        end
        S_ADDR: begin
          kind_reg  <= 2'd1;
          byte_reg  <= addr_byte;
          start_reg <= 1'b1;
          acnt_reg  <= acnt_reg + 3'd1;
          ret_reg   <= (acnt_reg + 3'd1 < addr_cycles) ? S_ADDR :
                       has_data ? S_DATA : (op_reg == `NPE_OP_BLK_STAT ? S_GAP : S_CMD);
          state_reg <= S_CYC;
        end
        S_DATA: begin
          kind_reg  <= 2'd2;
          byte_reg  <= page_buf[idx_reg - last_col];
          start_reg <= 1'b1;
          idx_reg   <= idx_reg + 10'd1;
          ret_reg   <= (idx_reg - last_col + 10'd1 < load_cnt_reg) ? S_DATA : S_CMD;
          state_reg <= S_CYC;
        end
        S_CYC: begin
          if (cyc_done) begin
            if (ret_reg == S_CMD || ret_reg == S_GAP) begin
              step_reg <= step_reg + 3'd1;
              acnt_reg <= 3'd0;
            end
            if (ret_reg == S_GAP) begin
              gap_reg <= WB_WAIT[7:0];
            end
            state_reg <= ret_reg;
          end
        end
        S_GAP: begin
          // Let the device pull ready/busy low before polling it
          if (gap_reg != 8'h00) begin
            gap_reg <= gap_reg - 8'h01;
          end else begin
            state_reg <= S_BUSY;
          end
        end
        S_BUSY: begin
          if (ready_busy_in) begin // RULE_24 RULE_18
            kind_reg  <= 2'd0;
            byte_reg  <= (op_reg == `NPE_OP_BLK_STAT) ? `NPE_CMD_BLK_STAT : `NPE_CMD_STATUS; // RULE_08 RULE_19
            start_reg <= (op_reg != `NPE_OP_BLK_STAT);
            step_reg  <= 3'd7;
            state_reg <= (op_reg == `NPE_OP_BLK_STAT) ? S_READ : S_WAIT;
          end
        end
        S_WAIT: begin
          if (cyc_done) begin
            state_reg <= S_READ;
          end
        end
        S_READ: begin
          if (step_reg == 3'd7) begin
            kind_reg  <= 2'd3;
            start_reg <= 1'b1;
            step_reg  <= 3'd6;
          end else if (cyc_done) begin
            result_reg        <= cyc_rd; // RULE_09 RULE_10 RULE_11 RULE_14 RULE_22
            chip_select_n_out <= 1'b1; // RULE_02
            if (op_reg == `NPE_OP_PROGRAM) begin
              load_cnt_reg <= 10'd0; // RULE_04
              area_reg     <= 2'd0; // RULE_01
            end
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// [common/npe_consts.vh]
/*
  Constants for the NAND program/erase/protect host controller:
  flash command codes, register offsets, field positions, timing counts.
  Assumes a 50 MHz system clock.
*/
`ifndef NPE_CONSTS_VH
`define NPE_CONSTS_VH

`define NPE_CMD_PTR_A      8'h00
`define NPE_CMD_PTR_B      8'h01
`define NPE_CMD_PTR_C      8'h50
`define NPE_CMD_DATA_IN    8'h80
`define NPE_CMD_PROG_GO    8'h10
`define NPE_CMD_ERASE_SET  8'h60
`define NPE_CMD_ERASE_GO   8'hD0
`define NPE_CMD_STATUS     8'h70
`define NPE_CMD_BLK_STAT   8'h7A
`define NPE_CMD_RESET      8'hFF
`define NPE_CMD_PROT_BASE  8'h40

`define NPE_OP_PROGRAM     3'h1
`define NPE_OP_ERASE       3'h2
`define NPE_OP_PROTECT     3'h3
`define NPE_OP_BLK_STAT    3'h4
`define NPE_OP_RESET       3'h5
`define NPE_OP_STATUS      3'h6

`define NPE_REG_CTRL       4'h0
`define NPE_REG_ADDR       4'h1
`define NPE_REG_STATUS     4'h2
`define NPE_REG_RESULT     4'h3
`define NPE_REG_DATA       4'h4
`define NPE_REG_COUNT      4'h5

`define NPE_CTRL_GO_BIT    0
`define NPE_CTRL_OP_LSB    1
`define NPE_CTRL_AREA_LSB  4
`define NPE_CTRL_PROT_LSB  6
`define NPE_ST_BUSY_BIT    0
`define NPE_ST_READY_BIT   6
`define NPE_ST_FAIL_BIT    0

`define NPE_PAGE_BYTES     10'd528
`define NPE_HALF_BYTES     10'd256
`define NPE_PROT_BLOCKS    13'd200

`define NPE_CLK_MHZ        50
`define NPE_T_STROBE_NS    40
`define NPE_T_STROBE_CYC   ((`NPE_T_STROBE_NS * `NPE_CLK_MHZ + 999) / 1000)
`define NPE_T_WB_NS        100
`define NPE_T_WB_CYC       ((`NPE_T_WB_NS * `NPE_CLK_MHZ + 999) / 1000)

`endif

// [core/npe_strobe.v]
/*
  Single bus cycle engine: drives one command, address, data-write or
  data-read cycle on the flash pins with stretched strobe phases.
  Assumes the flash pins are synchronous to mclk_in.
*/
`timescale 1ns/1ps
`include "npe_consts.vh"

module npe_strobe #(
  parameter PHASE = `NPE_T_STROBE_CYC
) (
  input  wire       mclk_in,
  input  wire       rst_in,
  input  wire       start_in,
  input  wire [1:0] kind_in,
  input  wire [7:0] byte_in,
  input  wire [7:0] io_in,
  output reg        done_out,
  output reg  [7:0] rd_data_out,
  output reg        cle_out,
  output reg        ale_out,
  output reg        write_strobe_n_out,
  output reg        read_strobe_n_out,
  output reg  [7:0] io_out,
  output reg        io_oe_out
);
  // kind: 0 command, 1 address, 2 data write, 3 data read
  localparam S_IDLE = 2'd0;
  localparam S_LOW  = 2'd1;
  localparam S_HIGH = 2'd2;

  reg [1:0] state_reg;
  reg [7:0] cnt_reg;
  reg [1:0] kind_reg;

  always @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg          <= S_IDLE;
      cnt_reg            <= 8'h00;
      kind_reg           <= 2'd0;
      done_out           <= 1'b0;
      rd_data_out        <= 8'h00;
      cle_out            <= 1'b0;
      ale_out            <= 1'b0;
      write_strobe_n_out <= 1'b1;
      read_strobe_n_out  <= 1'b1;
      io_out             <= 8'h00;
      io_oe_out          <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (start_in) begin
            kind_reg           <= kind_in;
            cle_out            <= (kind_in == 2'd0);
            ale_out            <= (kind_in == 2'd1);
            io_out             <= byte_in;
            io_oe_out          <= (kind_in != 2'd3);
            write_strobe_n_out <= (kind_in == 2'd3);
            read_strobe_n_out  <= (kind_in != 2'd3);
            cnt_reg            <= PHASE[7:0];
            state_reg          <= S_LOW;
          end
        end
        S_LOW: begin
          if (cnt_reg > 8'h01) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else begin
            if (kind_reg == 2'd3) begin
              rd_data_out <= io_in;
            end
            write_strobe_n_out <= 1'b1;
            read_strobe_n_out  <= 1'b1;
            cnt_reg            <= PHASE[7:0];
            state_reg          <= S_HIGH;
          end
        end
        S_HIGH: begin
          if (cnt_reg > 8'h01) begin
            cnt_reg <= cnt_reg - 8'h01;
          end else begin
            cle_out   <= 1'b0;
            ale_out   <= 1'b0;
            io_oe_out <= 1'b0;
            done_out  <= 1'b1;
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

// [dv/npe_host_monitor.sv]
/* Port checker for npe_host: Avalon handshake and flash pin sequencing.
   Assumes the ready/busy line is pulled up and that it is bound to npe_host. */
`timescale 1ns/1ps
module npe_host_monitor (
  input wire        mclk_in,
  input wire        rst_in,
  input wire [3:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire        ready_busy_in,
  input wire [7:0]  io_in,
  input wire [7:0]  io_out,
  input wire        io_oe_out,
  input wire        cle_out,
  input wire        ale_out,
  input wire        chip_select_n_out,
  input wire        write_strobe_n_out,
  input wire        read_strobe_n_out
);
  reg       we_d_reg;
  reg       prot_reg;
  reg [9:0] data_cnt_reg;
  wire      latch = !we_d_reg && write_strobe_n_out && !chip_select_n_out;
  // Bytes loaded since the last command, and whether a protect code opened it
  always @(posedge mclk_in) begin
    if (rst_in) begin
      we_d_reg <= 1'b1;
      prot_reg <= 1'b0;
      data_cnt_reg <= 10'h000;
    end else begin
      we_d_reg <= write_strobe_n_out;
      if (latch && cle_out) begin
        data_cnt_reg <= 10'h000;
        prot_reg <= io_out[7:4] == 4'h4 || (prot_reg && io_out == 8'h80);
      end else if (latch && !ale_out && data_cnt_reg != 10'h3FF) begin
        data_cnt_reg <= data_cnt_reg + 10'h001;
      end
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  sequence s_cmd;
    latch && cle_out;
  endsequence
  sequence s_confirm;
    s_cmd ##0 (io_out == 8'h10 || io_out == 8'hD0);
  endsequence
  wait_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("waitrequest not low one cycle after request");
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  busy_cmd_a: assert property (s_cmd ##0 !ready_busy_in |-> io_out == 8'h70 || io_out == 8'hFF)
    else $error("command other than status or reset sent while busy");
  confirm_data_a: assert property (s_cmd ##0 io_out == 8'h10 |-> data_cnt_reg != 10'h000 || prot_reg)
    else $error("program confirm sent without loaded data");
  confirm_wait_a: assert property (s_confirm |=> write_strobe_n_out [*4])
    else $error("flash cycle issued too soon after confirm");
  strobe_width_a: assert property ($fell(write_strobe_n_out) |=> !write_strobe_n_out ##1 write_strobe_n_out)
    else $error("write strobe low phase not two cycles");
  read_dir_a: assert property (!read_strobe_n_out |-> !io_oe_out && !chip_select_n_out && write_strobe_n_out)
    else $error("bus driven or deselected during read strobe");
  write_drive_a: assert property (!write_strobe_n_out |-> io_oe_out && !chip_select_n_out)
    else $error("write strobe without bus drive or select");
  latch_kind_a: assert property (latch |-> !(cle_out && ale_out))
    else $error("command and address latch high together");
endmodule
bind npe_host npe_host_monitor npe_host_monitor_inst (.mclk_in(mclk_in), .rst_in(rst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .ready_busy_in(ready_busy_in), .io_in(io_in),
  .io_out(io_out), .io_oe_out(io_oe_out), .cle_out(cle_out), .ale_out(ale_out),
  .chip_select_n_out(chip_select_n_out), .write_strobe_n_out(write_strobe_n_out),
  .read_strobe_n_out(read_strobe_n_out));

// [dv/npe_flash_model.sv]
/* Behavioural byte-wide NAND flash with shortened busy times.
   Assumes pins synchronous to mclk_in and a pulled-up ready/busy line. */
`timescale 1ns/1ps
module npe_flash_model #(
  parameter [7:0] PROG_CYC = 8'h28,
  parameter [7:0] LOAD_CYC = 8'h08
) (
  input  wire       mclk_in,
  input  wire       rst_in,
  input  wire       cle_in,
  input  wire       ale_in,
  input  wire       cs_n_in,
  input  wire       we_n_in,
  input  wire       re_n_in,
  input  wire [7:0] io_in,
  input  wire       fail_in,
  output wire [7:0] io_out,
  output wire       ready_busy_out
);
  reg         we_d_reg;
  reg         load_reg;
  reg         erase_reg;
  reg         blk_mode_reg;
  reg         fail_reg;
  reg         ptr_b_reg;
  reg  [7:0]  busy_reg;
  reg  [7:0]  a0_reg;
  reg  [7:0]  pcode_reg;
  reg  [23:0] sh_reg;
  reg  [63:0] cmd_log_reg;
  reg  [1:0]  prot_reg [0:255];
  int         n_addr_reg;
  int         n_data_reg;
  int         conf_addr_reg;
  int         conf_data_reg;
  wire        latch = !we_d_reg && we_n_in && !cs_n_in;
  wire [7:0]  blk = {sh_reg[12:8], sh_reg[23:21]};
  wire [7:0]  stat = blk_mode_reg ? {1'b1, ready_busy_out, 4'h0, prot_reg[blk]}
                                  : {1'b1, ready_busy_out, 5'h00, fail_reg};
  assign ready_busy_out = busy_reg == 8'h00;
  // A released bus shows the inverse of the status byte
  assign io_out = (!re_n_in && !cs_n_in) ? stat : ~stat;
  initial for (int i = 0; i < 256; i++) prot_reg[i] = 2'h0;
  always @(posedge mclk_in) begin
    we_d_reg <= rst_in | we_n_in;
    if (busy_reg != 8'h00)
      busy_reg <= busy_reg - 8'h01;
    if (rst_in) begin
      busy_reg <= 8'h00;
      {load_reg, erase_reg, blk_mode_reg, fail_reg, ptr_b_reg} <= 5'h00;
      pcode_reg <= 8'h00;
      cmd_log_reg <= 64'h0;
    end else if (latch && cle_in) begin
      cmd_log_reg <= {cmd_log_reg[55:0], io_in};
      n_addr_reg <= 0;
      n_data_reg <= 0;
      if (busy_reg == 8'h00 || io_in == 8'h70 || io_in == 8'hFF) begin
        case (io_in)
          8'h01: ptr_b_reg <= 1'b1;
          8'h00, 8'h50: ptr_b_reg <= 1'b0;
          8'h80: load_reg <= 1'b1;
          8'h60: erase_reg <= 1'b1;
          8'h70: blk_mode_reg <= 1'b0;
          8'h7A: blk_mode_reg <= 1'b1;
          8'h41, 8'h42, 8'h43: pcode_reg <= io_in;
          8'h10: if (load_reg && (n_data_reg != 0 || pcode_reg != 8'h00)) begin
            conf_addr_reg <= n_addr_reg;
            conf_data_reg <= n_data_reg;
            load_reg <= 1'b0;
            ptr_b_reg <= 1'b0;
            fail_reg <= fail_in;
            if (pcode_reg != 8'h00)
              prot_reg[blk] <= pcode_reg[1:0];
            busy_reg <= prot_reg[blk][0] ? LOAD_CYC : PROG_CYC;
            pcode_reg <= 8'h00;
          end
          8'hD0: if (erase_reg) begin
            erase_reg <= 1'b0;
            conf_addr_reg <= n_addr_reg;
            fail_reg <= fail_in;
            busy_reg <= prot_reg[blk][1] ? LOAD_CYC : PROG_CYC;
            if (prot_reg[blk] == 2'h1)
              prot_reg[blk] <= 2'h0;
          end
          8'hFF: begin
            busy_reg <= LOAD_CYC;
            {load_reg, erase_reg} <= 2'h0;
            pcode_reg <= 8'h00;
          end
          default: ;
        endcase
      end
    end else if (latch && ale_in) begin
      sh_reg <= {sh_reg[15:0], io_in};
      if (n_addr_reg == 0)
        a0_reg <= io_in;
      n_addr_reg <= n_addr_reg + 1;
    end else if (latch && n_data_reg < 528) begin
      n_data_reg <= n_data_reg + 1;
    end
  end
endmodule

// [dv/test_npe_host.sv]
/* Self-checking bench for npe_host driving a behavioural flash.
   Software orders go over Avalon-MM; pin traffic is judged through the model. */
`timescale 1ns/1ps
module test_npe_host;
  reg         mclk_in = 1'b0;
  reg         rst_in = 1'b1;
  reg  [3:0]  addr = 4'h0;
  reg         rd = 1'b0;
  reg         wr = 1'b0;
  reg  [31:0] wdata = 32'h0;
  reg         fail = 1'b0;
  reg  [31:0] v;
  wire [31:0] rdata;
  wire        waitreq, rb, oe, cle, ale, cs_n, we_n, re_n;
  wire [7:0]  h_io;
  wire [7:0]  f_io;
  wire [7:0]  bus = oe ? h_io : f_io;
  wire [63:0] log_w = npe_flash_model_inst.cmd_log_reg;
  wire [31:0] a0_w = {24'h0, npe_flash_model_inst.a0_reg};
  wire [31:0] ca_w = npe_flash_model_inst.conf_addr_reg;
  wire [31:0] cd_w = npe_flash_model_inst.conf_data_reg;
  integer     error_cnt = 0;
  integer     n_compared = 0;
  integer     cycles = 0;
  integer     i;
  npe_host npe_host_inst (.mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .ready_busy_in(rb), .io_in(bus), .io_out(h_io),
    .io_oe_out(oe), .cle_out(cle), .ale_out(ale), .chip_select_n_out(cs_n),
    .write_strobe_n_out(we_n), .read_strobe_n_out(re_n));
  npe_flash_model npe_flash_model_inst (.mclk_in(mclk_in), .rst_in(rst_in), .cle_in(cle),
    .ale_in(ale), .cs_n_in(cs_n), .we_n_in(we_n), .re_n_in(re_n), .io_in(bus),
    .fail_in(fail), .io_out(f_io), .ready_busy_out(rb));
  initial forever #10 mclk_in = ~mclk_in;
  task stop_test;
    begin
      if (error_cnt == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt = error_cnt + 1;
      stop_test;
    end
  end
  task av_xfer(input [3:0] a, input [31:0] d, input w);
    begin
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      @(posedge mclk_in);
      while (waitreq !== 1'b0) @(posedge mclk_in);
      v = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge mclk_in);
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rd_chk(input [3:0] a, input [31:0] exp);
    begin
      av_xfer(a, 32'h0, 1'b0);
      chk(v, exp);
    end
  endtask
  // Start a sequence and poll STATUS until the busy bit clears
  task go(input [31:0] ctrl);
    begin
      av_xfer(4'h0, ctrl, 1'b1);
      v = 32'h1;
      while (v[0] !== 1'b0) av_xfer(4'h2, 32'h0, 1'b0);
    end
  endtask
  initial begin
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd_chk(4'h2, 32'h4);
    rd_chk(4'hF, 32'h0);
    go(32'h3);
    rd_chk(4'h2, 32'h6);
    chk(log_w[31:0], 32'h0);
    av_xfer(4'h1, 32'h0012345, 1'b1);
    for (i = 0; i < 530; i = i + 1) av_xfer(4'h4, i, 1'b1);
    rd_chk(4'h5, 32'd528);
    go(32'h13);
    chk(log_w[31:0], 32'h01801070);
    chk(ca_w, 32'h4);
    chk(cd_w, 32'd528);
    rd_chk(4'h3, 32'hC0);
    rd_chk(4'h5, 32'h0);
    for (i = 0; i < 3; i = i + 1) begin
      fail <= i == 2;
      av_xfer(4'h4, 32'h5A, 1'b1);
      go(32'h3 | (i << 4));
      chk(log_w[31:0], {(i == 2) ? 8'h50 : i[7:0], 24'h801070});
      rd_chk(4'h3, 32'hC0 | (i == 2));
    end
    fail <= 1'b0;
    av_xfer(4'h1, 32'hA700, 1'b1);
    go(32'h5);
    chk({8'h0, log_w[23:0]}, 32'h60D070);
    chk(ca_w, 32'h3);
    chk(a0_w, 32'hA0);
    rd_chk(4'h3, 32'hC0);
    for (i = 1; i < 4; i = i + 1) begin
      av_xfer(4'h1, i << 13, 1'b1);
      go(32'h7 | (i << 6));
      chk(log_w[31:0], {8'h40 | i[7:0], 24'h801070});
      chk(a0_w, 32'h0);
      chk(cd_w, 32'h0);
      go(32'h9);
      chk({24'h0, log_w[7:0]}, 32'h7A);
      rd_chk(4'h3, 32'hC0 | i);
      go(32'h5);
      go(32'h9);
      rd_chk(4'h3, (i == 1) ? 32'hC0 : 32'hC0 | i);
    end
    av_xfer(4'h1, 32'd200 << 13, 1'b1);
    go(32'h47);
    rd_chk(4'h2, 32'h6);
    chk({24'h0, log_w[7:0]}, 32'h7A);
    go(32'hB);
    chk({16'h0, log_w[15:0]}, 32'hFF70);
    rd_chk(4'h3, 32'hC0);
    stop_test;
  end
endmodule
